// ==== rtl/nfc_pkg.sv ====
/*
 * nfc_pkg: constants for the host-side nand page controller.
 * assumes a 100 MHz system clock and an eight-bit multiplexed flash bus.
 */
package nfc_pkg;
	// ----------------------------------------------------------------
	// flash command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
	localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
	localparam logic [7:0] CMD_CACHE_READ   = 8'h31;
	localparam logic [7:0] CMD_CACHE_END    = 8'h34;
	localparam logic [7:0] CMD_RAND_OUT     = 8'h05;
	localparam logic [7:0] CMD_RAND_OUT_CFM = 8'hE0;
	localparam logic [7:0] CMD_PROG_LOAD    = 8'h80;
	localparam logic [7:0] CMD_RAND_IN      = 8'h85;
	localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
	localparam logic [7:0] CMD_CACHE_PROG   = 8'h15;
	localparam logic [7:0] CMD_STATUS       = 8'h70;
	localparam logic [7:0] CMD_RESET        = 8'hFF;
	// ----------------------------------------------------------------
	// software register map (word index on the local port)
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL   = 4'h0;  // w: start op, r: busy/state
	localparam logic [3:0] REG_COL    = 4'h1;  // column address, 12 bits
	localparam logic [3:0] REG_ROW    = 4'h2;  // row address, 16 bits
	localparam logic [3:0] REG_COUNT  = 4'h3;  // bytes to move
	localparam logic [3:0] REG_DATA   = 4'h4;  // w: tx byte, r: last rx byte
	localparam logic [3:0] REG_STATUS = 4'h5;  // last status byte from a status op
	localparam logic [3:0] REG_WP     = 4'h6;  // write protect release
	// ----------------------------------------------------------------
	// control word fields
	// ----------------------------------------------------------------
	localparam int CTRL_GO_BIT = 4;
	// op codes in control bits 3:0
	localparam logic [3:0] OP_PAGE_READ  = 4'h0_1;
	localparam logic [3:0] OP_RAND_OUT   = 4'h2;
	localparam logic [3:0] OP_CACHE_READ = 4'h3;
	localparam logic [3:0] OP_CACHE_END  = 4'h4;
	localparam logic [3:0] OP_PROGRAM    = 4'h5;
	localparam logic [3:0] OP_CACHE_PROG = 4'h6;
	localparam logic [3:0] OP_STATUS     = 4'h7;
	localparam logic [3:0] OP_RESET      = 4'h8;
	localparam logic [3:0] OP_RAND_IN    = 4'h9;
	localparam logic [3:0] OP_READ_DATA  = 4'hA;
	localparam logic [3:0] OP_WRITE_DATA = 4'hB;
	// status bit positions
	localparam int SR_PASS_FAIL   = 0;
	localparam int SR_CACHE_PF    = 1;
	localparam int SR_ARRAY_READY = 5;
	localparam int SR_CACHE_READY = 6;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int STROBE_NS       = 30;  // strobe low and high phase
	localparam int STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CACHE_END_US    = 5;
	localparam int CACHE_END_CYC   = CACHE_END_US * 1000 / CLK_PERIOD_NS;
	localparam int MAX_PARTIAL     = 4;
	localparam int PAGE_BYTES      = 2112;
endpackage : nfc_pkg

// ==== rtl/nfc_host.sv ====
/*
 * nfc_host: host-side controller for an eight-bit nand flash page interface.
 * software drives it through a small local register port; the flash pins
 * are driven directly. assumes all inputs synchronous to i_clk.
 */
`timescale 1ns/10ps
// Overview of operation
// (RL1) raise chip select when idle, saving power
// (RL2) each read strobe fall fetches next byte
// (RL3) latch selects mark command, address, data
// (RL4) program refused by flash while protect low
// (RL5) hold write protect low until enabled
// (RL6) wait on ready_busy_n before continuing
// (RL7) flash starts in read mode
// (RL8) page read: 00h, address, 30h, wait
// (RL9) random out: 05h, column, E0h
// (RL10) chip select toggles never abort reads
// (RL11) cache read: 00h, column zero, 31h
// (RL12) status ready bits tracked from status byte
// (RL13) after status in cache read send 00h
// (RL14) cache end 34h, idle within 5 us
// (RL15) program: 80h, address, data, 10h
// (RL16) at most four partial programs per page
// (RL17) pass_fail_bit reported from status
// (RL18) only status or reset while programming
// (RL19) cache program confirms with 15h
// (RL20) next cache program after cache ready
// (RL21) ready pin users end with 10h
// (RL22) both pass/fail bits kept from status
// (RL23) status mode holds until next command
// (RL24) reset FFh aborts any operation
// (RL25) address is two column, two row bytes
module nfc_host (
	// clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	// local register port
	input  wire logic [3:0] i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [15:0] o_rdata,
	// flash pins
	output logic            o_ce_n,
	output logic            o_cle,
	output logic            o_ale,
	output logic            o_we_n,
	output logic            o_re_n,
	output logic            o_wp_n,
	output logic      [7:0] o_io,
	output logic            o_io_oe_n,
	input  wire logic [7:0] i_io,
	input  wire logic       i_rb_n
);
	import nfc_pkg::*;

	typedef enum {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_WAIT_BUSY, ST_WAIT_READY,
		ST_END_WAIT} nfc_state_t;

	// ----------------------------------------------------------------
	// sequencing state
	// ----------------------------------------------------------------
	nfc_state_t  state_reg, state_next;
	logic [7:0]  seq_reg [0:7];          // byte script: value
	logic [1:0]  kind_reg [0:7];         // 0 cmd, 1 addr, 2 wdata, 3 rdata
	logic [7:0]  seq_next [0:7];
	logic [1:0]  kind_next [0:7];
	logic [2:0]  len_reg, len_next, idx_reg, idx_next;
	logic        wait_reg, wait_next;    // wait busy/ready after script
	logic [3:0]  op_reg, op_next;
	logic [11:0] col_reg, col_next;
	logic [15:0] row_reg, row_next;
	logic [7:0]  tx_reg, tx_next, rx_reg, rx_next, sr_reg, sr_next;
	logic [11:0] cnt_reg, cnt_next;
	logic [9:0]  tmr_reg, tmr_next;
	logic        wp_reg, wp_next, cache_rd_reg, cache_rd_next;
	logic        status_mode_reg, status_mode_next, prog_busy_reg, prog_busy_next;
	logic [2:0]  partial_reg, partial_next;
	logic [15:0] rdata_reg, rdata_next;
	logic        go;

	assign go = i_wr && (i_addr == REG_CTRL) && i_wdata[CTRL_GO_BIT];

	// next-state for the script engine and software registers
	always_comb begin
		state_next = state_reg;
		len_next = len_reg;
		idx_next = idx_reg;
		wait_next = wait_reg;
		op_next = op_reg;
		col_next = col_reg;
		row_next = row_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		sr_next = sr_reg;
		cnt_next = cnt_reg;
		tmr_next = tmr_reg;
		wp_next = wp_reg;
		cache_rd_next = cache_rd_reg;
		status_mode_next = status_mode_reg;
		prog_busy_next = prog_busy_reg;
		partial_next = partial_reg;
		rdata_next = 16'h0000;
		for (int k = 0; k < 8; k++) begin
			seq_next[k] = seq_reg[k];
			kind_next[k] = kind_reg[k];
		end
		// software writes, only taken while idle
		if (i_wr && state_reg == ST_IDLE) begin
			case (i_addr)
				REG_COL:  col_next = i_wdata[11:0];
				REG_ROW: begin
					// a new page starts a fresh partial-program count
					row_next = i_wdata;
					if (i_wdata != row_reg)
						partial_next = 3'd0;  // RL16
				end
				REG_COUNT: cnt_next = i_wdata[11:0];
				REG_DATA: tx_next = i_wdata[7:0];
				REG_WP:   wp_next = i_wdata[0];  // RL5
				default: ;
			endcase
		end
		// read data one cycle after the strobe
		if (i_rd) begin
			case (i_addr)
				REG_CTRL:   rdata_next = {7'h00, cache_rd_reg, prog_busy_reg, status_mode_reg,
					partial_reg, state_reg != ST_IDLE, i_rb_n, 1'b0};
				REG_COL:    rdata_next = {4'h0, col_reg};
				REG_ROW:    rdata_next = row_reg;
				REG_COUNT:  rdata_next = {4'h0, cnt_reg};
				REG_DATA:   rdata_next = {8'h00, rx_reg};
				REG_STATUS: rdata_next = {8'h00, sr_reg};  // RL12 RL17 RL22
				REG_WP:     rdata_next = {15'h0000, wp_reg};
				default:    rdata_next = 16'h0000;
			endcase
		end
		case (state_reg)
			ST_IDLE: begin
				if (go) begin
					op_next = i_wdata[3:0];
					idx_next = 3'd0;
					wait_next = 1'b0;
					state_next = ST_SETUP;
					len_next = 3'd1;
					kind_next[0] = 2'd0;
					case (i_wdata[3:0])
						OP_PAGE_READ, OP_CACHE_READ, OP_PROGRAM: begin
							// RL8 RL11 RL15 RL25 command then four address bytes
							seq_next[0] = (i_wdata[3:0] == OP_PROGRAM) ?
								CMD_PROG_LOAD : CMD_READ_SETUP;
							seq_next[1] = (i_wdata[3:0] == OP_CACHE_READ) ?
								8'h00 : col_reg[7:0];  // RL11
							seq_next[2] = (i_wdata[3:0] == OP_CACHE_READ) ?
								8'h00 : {4'h0, col_reg[11:8]};
							seq_next[3] = row_reg[7:0];
							seq_next[4] = row_reg[15:8];
							for (int k = 1; k < 5; k++) kind_next[k] = 2'd1;
							seq_next[5] = (i_wdata[3:0] == OP_CACHE_READ) ?
								CMD_CACHE_READ : CMD_READ_CONFIRM;
							kind_next[5] = 2'd0;
							len_next = (i_wdata[3:0] == OP_PROGRAM) ? 3'd5 : 3'd6;
							wait_next = (i_wdata[3:0] != OP_PROGRAM);  // RL6 RL8
							cache_rd_next = (i_wdata[3:0] == OP_CACHE_READ);
						end
						OP_RAND_OUT, OP_RAND_IN: begin
							// RL9 column only; random out refused during cache read
							seq_next[0] = (i_wdata[3:0] == OP_RAND_IN) ? CMD_RAND_IN : CMD_RAND_OUT;
							seq_next[1] = col_reg[7:0];
							seq_next[2] = {4'h0, col_reg[11:8]};
							kind_next[1] = 2'd1;
							kind_next[2] = 2'd1;
							seq_next[3] = CMD_RAND_OUT_CFM;
							kind_next[3] = 2'd0;
							len_next = (i_wdata[3:0] == OP_RAND_IN) ? 3'd3 : 3'd4;
							if (cache_rd_reg && i_wdata[3:0] == OP_RAND_OUT)
								state_next = ST_IDLE;  // RL9
						end
						OP_CACHE_PROG: begin
							// RL19 RL20 RL21 RL16 confirm chosen by bit 5
							seq_next[0] = i_wdata[5] ? CMD_PROG_CONFIRM : CMD_CACHE_PROG;
							wait_next = 1'b1;
							// a refused confirm must not leave the busy flag behind
							if (partial_reg == 3'(MAX_PARTIAL))
								state_next = ST_IDLE;  // RL16
							else begin
								partial_next = partial_reg + 3'd1;
								prog_busy_next = 1'b1;  // RL18
							end
						end
						OP_STATUS: begin
							seq_next[0] = CMD_STATUS;  // RL23
							seq_next[1] = 8'h00;
							kind_next[1] = 2'd3;
							len_next = 3'd2;
						end
						OP_CACHE_END: begin
							seq_next[0] = CMD_CACHE_END;  // RL14
							tmr_next = 10'(CACHE_END_CYC);
						end
						OP_RESET: begin
							seq_next[0] = CMD_RESET;  // RL24
							wait_next = 1'b1;
						end
						OP_READ_DATA: begin
							// RL13 resume cache output after status
							seq_next[0] = CMD_READ_SETUP;
							kind_next[0] = status_mode_reg ? 2'd0 : 2'd3;
							kind_next[1] = 2'd3;
							seq_next[1] = 8'h00;
							len_next = status_mode_reg ? 3'd2 : 3'd1;
						end
						OP_WRITE_DATA: begin
							seq_next[0] = tx_reg;
							kind_next[0] = 2'd2;
						end
						default: state_next = ST_IDLE;
					endcase
					// RL18 only status or reset while programming
					if (prog_busy_reg && !i_rb_n && i_wdata[3:0] != OP_STATUS &&
						i_wdata[3:0] != OP_RESET)
						state_next = ST_IDLE;
				end
			end
			ST_SETUP: begin
				tmr_next = 10'(STROBE_CYC);
				state_next = ST_PULSE;
			end
			ST_PULSE: begin
				// strobe low phase
				if (tmr_reg == 10'd0) begin
					if (kind_reg[idx_reg] == 2'd3)
						rx_next = i_io;  // RL2
					if (kind_reg[idx_reg] == 2'd3 && op_reg == OP_STATUS)
						sr_next = i_io;
					tmr_next = 10'(STROBE_CYC);
					state_next = ST_HOLD;
				end else
					tmr_next = tmr_reg - 10'd1;
			end
			ST_HOLD: begin
				if (tmr_reg != 10'd0)
					tmr_next = tmr_reg - 10'd1;
				else if (idx_reg + 3'd1 < len_reg) begin
					idx_next = idx_reg + 3'd1;
					state_next = ST_SETUP;
				end else if ((op_reg == OP_READ_DATA || op_reg == OP_WRITE_DATA) &&
					cnt_reg > 12'd1) begin
					// stream: repeat the data byte until the count runs out
					cnt_next = cnt_reg - 12'd1;  // RL2
					state_next = ST_SETUP;
				end else begin
					// only a command byte changes the flash's output mode;
					// a data byte of 70h must not look like a status request
					if (kind_reg[0] == 2'd0)
						status_mode_next = (op_reg == OP_STATUS);  // RL23
					if (op_reg == OP_CACHE_END) begin
						tmr_next = 10'(CACHE_END_CYC);
						cache_rd_next = 1'b0;
						state_next = ST_END_WAIT;
					end else if (wait_reg)
						state_next = ST_WAIT_BUSY;
					else
						state_next = ST_IDLE;
					if (op_reg == OP_RESET)
						cache_rd_next = 1'b0;
				end
			end
			ST_WAIT_BUSY: begin
				tmr_next = tmr_reg + 10'd1;
				if (!i_rb_n || tmr_reg == 10'd1000)
					state_next = ST_WAIT_READY;  // RL6
			end
			ST_WAIT_READY: begin
				if (i_rb_n) begin
					prog_busy_next = 1'b0;
					state_next = ST_IDLE;  // RL8
				end
			end
			ST_END_WAIT: begin
				if (tmr_reg == 10'd0)
					state_next = ST_IDLE;  // RL14
				else
					tmr_next = tmr_reg - 10'd1;
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// register everything
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_reg <= ST_IDLE;
			len_reg <= 3'd0;
			idx_reg <= 3'd0;
			wait_reg <= 1'b0;
			op_reg <= 4'h0;
			col_reg <= 12'h000;
			row_reg <= 16'h0000;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			sr_reg <= 8'h00;
			cnt_reg <= 12'h000;
			tmr_reg <= 10'd0;
			wp_reg <= 1'b0;  // RL5
			cache_rd_reg <= 1'b0;
			status_mode_reg <= 1'b0;  // RL7
			prog_busy_reg <= 1'b0;
			partial_reg <= 3'd0;
			rdata_reg <= 16'h0000;
			for (int k = 0; k < 8; k++) begin
				seq_reg[k] <= 8'h00;
				kind_reg[k] <= 2'd0;
			end
		end else begin
			state_reg <= state_next;
			len_reg <= len_next;
			idx_reg <= idx_next;
			wait_reg <= wait_next;
			op_reg <= op_next;
			col_reg <= col_next;
			row_reg <= row_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			sr_reg <= sr_next;
			cnt_reg <= cnt_next;
			tmr_reg <= tmr_next;
			wp_reg <= wp_next;
			cache_rd_reg <= cache_rd_next;
			status_mode_reg <= status_mode_next;
			prog_busy_reg <= prog_busy_next;
			partial_reg <= partial_next;
			rdata_reg <= rdata_next;
			for (int k = 0; k < 8; k++) begin
				seq_reg[k] <= seq_next[k];
				kind_reg[k] <= kind_next[k];
			end
		end
	end

	// ----------------------------------------------------------------
	// pin drive
	// ----------------------------------------------------------------
	// chip select low only while a byte is strobed, high through busy waits; toggling it is harmless anyway
	logic active;
	assign active = (state_reg == ST_SETUP) || (state_reg == ST_PULSE) ||
		(state_reg == ST_HOLD);
	assign o_ce_n = !active;  // RL1 RL10
	assign o_cle = active && kind_reg[idx_reg] == 2'd0;  // RL3
	assign o_ale = active && kind_reg[idx_reg] == 2'd1;  // RL3
	assign o_we_n = !(state_reg == ST_PULSE && kind_reg[idx_reg] != 2'd3);  // RL3
	assign o_re_n = !(state_reg == ST_PULSE && kind_reg[idx_reg] == 2'd3);  // RL2
	assign o_wp_n = wp_reg;  // RL4 RL5
	assign o_io = seq_reg[idx_reg];
	assign o_io_oe_n = !(active && kind_reg[idx_reg] != 2'd3);
	assign o_rdata = rdata_reg;
endmodule : nfc_host

// ==== testbench/nfc_host_monitor.sv ====
/* nfc_host_monitor: flash pin protocol checks on the host controller.
   assumes one clock domain, reset asynchronous and active high. */
`timescale 1ns/10ps
module nfc_host_monitor
	import nfc_pkg::*;
(
	// clock, reset, local port
	input wire logic	i_clk,
	input wire logic	i_reset,
	input wire logic [3:0]	i_addr,
	input wire logic	i_wr,
	// flash pins
	input wire logic	o_ce_n,
	input wire logic	o_cle,
	input wire logic	o_ale,
	input wire logic	o_we_n,
	input wire logic	o_re_n,
	input wire logic	o_wp_n,
	input wire logic [7:0]	o_io,
	input wire logic	o_io_oe_n,
	input wire logic	i_rb_n
);
	default clocking mon_cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// ----
	// strobe, latch, bus and write protect checks
	// ----
	a_latch_onehot: assert property (!o_we_n |-> !(o_cle && o_ale))
		else $error("cle and ale both high");
	a_strobe_excl: assert property (!(!o_we_n && !o_re_n))
		else $error("both strobes low");
	a_write_pulse: assert property ($fell(o_we_n) |-> (!o_we_n)[*4] ##1 o_we_n)
		else $error("write strobe width");
	// selects and bus held across the latching edge, else a wrong byte lands
	a_latch_hold: assert property ($rose(o_we_n) |-> $stable(o_io) && $stable(o_cle) && $stable(o_ale))
		else $error("bus moved at latch edge");
	a_bus_driven: assert property (!o_we_n |-> !o_io_oe_n)
		else $error("bus not driven in write");
	a_bus_released: assert property (!o_re_n |-> o_io_oe_n)
		else $error("bus driven in read");
	a_strobe_select: assert property ((!o_we_n || !o_re_n) |-> !o_ce_n)
		else $error("strobe while deselected");
	a_busy_cmd_only: assert property ((!i_rb_n && !o_we_n) |-> o_cle)
		else $error("address or data while busy");
	a_wp_from_reg: assert property ($rose(o_wp_n) |-> $past(i_wr) && $past(i_addr) == REG_WP)
		else $error("protect released unasked");
endmodule : nfc_host_monitor
bind nfc_host nfc_host_monitor mon (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
	.i_wr(i_wr), .o_ce_n(o_ce_n), .o_cle(o_cle), .o_ale(o_ale), .o_we_n(o_we_n),
	.o_re_n(o_re_n), .o_wp_n(o_wp_n), .o_io(o_io), .o_io_oe_n(o_io_oe_n), .i_rb_n(i_rb_n));

// ==== testbench/nfc_flash_model.sv ====
/* nfc_flash_model: behavioural flash device for the host bench.
   assumes the host makes every strobe; busy time is shortened. */
`timescale 1ns/10ps
module nfc_flash_model #(
	parameter int T_BUSY_NS = 1500
) (
	// host side pins
	input wire logic	i_ce_n,
	input wire logic	i_cle,
	input wire logic	i_ale,
	input wire logic	i_we_n,
	input wire logic	i_re_n,
	input wire logic	i_wp_n,
	input wire logic [7:0]	i_io,
	// device outputs, fault select
	output logic [7:0]	o_io,
	output logic		o_rb_n,
	input wire logic	i_fail
);
	logic [7:0]	arr [256];
	logic [7:0]	pg [256];
	logic [7:0]	last_cmd, dout, sr;
	logic [11:0]	col = 12'h000;
	logic [15:0]	row = 16'h0000;
	logic		stat_mode = 1'b0;
	logic		cache_rd = 1'b0;
	int		addr_n = 0;
	int		seq = 0;
	// power-up: ready and in read mode, page buffer preset
	initial begin
		o_rb_n = 1'b1;
		sr = 8'h00;
		last_cmd = 8'h00;
		dout = 8'h00;
		for (int i = 0; i < 256; i++) begin
			arr[i] = 8'(i) ^ 8'h5A;
			pg[i] = arr[i];
		end
	end
	// busy timer; chip select is ignored, only reset cuts it short
	task automatic go_busy;
		int s;
		seq++;
		s = seq;
		o_rb_n = 1'b0;
		fork begin
			#(T_BUSY_NS);
			if (s == seq)
				o_rb_n = 1'b1;
		end join_none
	endtask : go_busy
	task automatic command(input logic [7:0] c);
		last_cmd = c;
		stat_mode = (c == 8'h70);
		if (c == 8'h00 || c == 8'h05 || c == 8'h80 || c == 8'h85)
			addr_n = 0;
		if (c == 8'h30 || c == 8'h31) begin
			pg = arr;
			cache_rd = (c == 8'h31);
			go_busy();
		end
		if (c == 8'h34) begin
			cache_rd = 1'b0;
			go_busy();
		end
		if ((c == 8'h10 || c == 8'h15) && i_wp_n) begin
			arr = pg;
			sr = {6'h00, sr[0], i_fail};
			go_busy();
		end
		if (c == 8'hFF) begin
			seq++;
			cache_rd = 1'b0;
			sr = 8'h00;
			o_rb_n = 1'b1;
		end
	endtask : command
	// capture on the rising write strobe; busy takes only 70h and FFh commands and address bytes
	always @(posedge i_we_n) begin
		if (!i_ce_n && i_cle && (o_rb_n || i_io == 8'h70 || i_io == 8'hFF))
			command(i_io);
		else if (!i_ce_n && i_ale) begin
			case (addr_n)
				0: col[7:0] = i_io;
				1: col[11:8] = i_io[3:0];
				2: row[7:0] = i_io;
				default: row[15:8] = i_io;
			endcase
			addr_n++;
		end else if (!i_ce_n && !i_cle && o_rb_n) begin
			pg[col[7:0]] = i_io;
			col++;
		end
	end
	// each falling read strobe presents a byte; outside status mode it steps the column
	always @(negedge i_re_n) begin
		if (!i_ce_n && stat_mode)
			dout = {i_wp_n, o_rb_n, o_rb_n, 3'b000, sr[1:0]};
		else if (!i_ce_n) begin
			dout = pg[col[7:0]];
			col++;
		end
	end
	// released bus shows the inverse so stale data never matches
	assign o_io = (!i_ce_n && !i_re_n) ? dout : ~dout;
endmodule : nfc_flash_model

// ==== testbench/nfc_host_tb_top.sv ====
/* nfc_host_tb_top: directed bench for the host controller and flash model.
   assumes the register map and op codes of nfc_pkg. */
`timescale 1ns/10ps
module nfc_host_tb_top;
	import nfc_pkg::*;
	logic		i_clk, i_reset, i_wr, i_rd, i_rb_n, fail;
	logic [3:0]	i_addr;
	logic [15:0]	i_wdata, o_rdata, rv;
	logic		o_ce_n, o_cle, o_ale, o_we_n, o_re_n, o_wp_n, o_io_oe_n;
	logic [7:0]	o_io, i_io;
	int		n_mismatch = 0;
	int		n_checks = 0;
	int		cyc = 0;
	nfc_host uut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_ce_n(o_ce_n), .o_cle(o_cle),
		.o_ale(o_ale), .o_we_n(o_we_n), .o_re_n(o_re_n), .o_wp_n(o_wp_n), .o_io(o_io),
		.o_io_oe_n(o_io_oe_n), .i_io(i_io), .i_rb_n(i_rb_n));
	nfc_flash_model fm (.i_ce_n(o_ce_n), .i_cle(o_cle), .i_ale(o_ale), .i_we_n(o_we_n),
		.i_re_n(o_re_n), .i_wp_n(o_wp_n), .i_io(o_io), .o_io(i_io), .o_rb_n(i_rb_n),
		.i_fail(fail));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// hang guard, far above the expected run length
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	task automatic chk(input string what, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		rv = o_rdata;
	endtask : rd
	// start an op, poll busy; bound covers the controller's own give-up wait
	task automatic run(input logic [3:0] op, input logic [15:0] xtra);
		wr(REG_CTRL, xtra | 16'(op) | (16'h0001 << CTRL_GO_BIT));
		for (int k = 0; k < 1500; k++) begin
			rd(REG_CTRL);
			if (rv[2] === 1'b0)
				break;
		end
		chk("busy", 16'(rv[2]), 16'h0000);
	endtask : run
	task automatic read_bytes(input logic [15:0] n);
		wr(REG_COUNT, n);
		run(OP_READ_DATA, 16'h0000);
		rd(REG_DATA);
	endtask : read_bytes
	// one-byte program of the data register at the current column, then fetch status
	task automatic prog(input logic [15:0] xtra);
		run(OP_PROGRAM, 16'h0000);
		wr(REG_COUNT, 16'h0001);
		run(OP_WRITE_DATA, 16'h0000);
		run(OP_CACHE_PROG, xtra);
		run(OP_STATUS, 16'h0000);
		rd(REG_STATUS);
	endtask : prog
	task automatic t_reads;
		chk("ce_n", 16'(o_ce_n), 16'h0001);
		chk("wp_n", 16'(o_wp_n), 16'h0000);
		wr(4'hF, 16'hFFFF);
		wr(REG_COL, 16'h0003);
		wr(REG_ROW, 16'h0102);
		run(OP_PAGE_READ, 16'h0000);
		chk("cmd", 16'(fm.last_cmd), 16'h0030);
		chk("row", fm.row, 16'h0102);
		read_bytes(16'h0002);
		chk("data", 16'(rv[7:0]), 16'h005E);
		wr(REG_COL, 16'h00A0);
		run(OP_RAND_OUT, 16'h0000);
		chk("addr cycles", 16'(fm.addr_n), 16'h0002);
		read_bytes(16'h0001);
		chk("data", 16'(rv[7:0]), 16'h00FA);
		$display("test reads done");
	endtask : t_reads
	// three partial programs on one page, within the allowed four
	task automatic t_program;
		wr(REG_WP, 16'h0001);
		wr(REG_COL, 16'h0007);
		wr(REG_DATA, 16'h00A5);
		prog(16'h0020);
		chk("cmd", 16'(fm.last_cmd), 16'h0070);
		chk("array", 16'(fm.arr[7]), 16'h00A5);
		chk("status", 16'(rv[7:0]), 16'h00E0);
		fail = 1'b1;
		prog(16'h0000);
		chk("status", 16'(rv[7:0]), 16'h00E1);
		fail = 1'b0;
		prog(16'h0020);
		chk("status", 16'(rv[7:0]), 16'h00E2);
		$display("test program done");
	endtask : t_program
	task automatic t_protect_cache;
		wr(REG_WP, 16'h0000);
		wr(REG_DATA, 16'h003C);
		prog(16'h0020);
		chk("array", 16'(fm.arr[7]), 16'h00A5);
		rd(REG_CTRL);
		chk("partial", 16'(rv[5:3]), 16'h0004);
		run(OP_CACHE_PROG, 16'h0020);
		chk("cmd", 16'(fm.last_cmd), 16'h0070);
		wr(REG_COL, 16'h0000);
		run(OP_CACHE_READ, 16'h0000);
		chk("cmd", 16'(fm.last_cmd), 16'h0031);
		read_bytes(16'h0001);
		chk("data", 16'(rv[7:0]), 16'h005A);
		run(OP_STATUS, 16'h0000);
		read_bytes(16'h0001);
		chk("resume", 16'(rv[7:0]), 16'h005B);
		run(OP_RAND_OUT, 16'h0000);
		chk("cmd", 16'(fm.last_cmd), 16'h0000);
		run(OP_CACHE_END, 16'h0000);
		chk("cmd", 16'(fm.last_cmd), 16'h0034);
		chk("ready", 16'(i_rb_n), 16'h0001);
		wr(REG_WP, 16'h0001);
		run(OP_RESET, 16'h0000);
		run(OP_STATUS, 16'h0000);
		rd(REG_STATUS);
		chk("status", 16'(rv[7:0]), 16'h00E0);
		$display("test protect_cache done");
	endtask : t_protect_cache
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	// reset, then the scenarios in order
	initial begin
		i_reset = 1'b1;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 4'h0;
		i_wdata = 16'h0000;
		fail = 1'b0;
		repeat (3) @(posedge i_clk);
		i_reset <= 1'b0;
		t_reads();
		t_program();
		t_protect_cache();
		end_of_test();
	end
endmodule : nfc_host_tb_top
